// >>> rtl/tmr_top.sv
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Contract
// [RULE1] Table holds exactly 32 entries, reached through the four entry registers.
// [RULE2] Slot select is 32 bits; a five-bit field picks one entry.
// [RULE3] Probe-failure flag at bit 31 sets on probe miss, clears on hit.
// [RULE4] Read and indexed write act on the entry named by slot select.
// [RULE5] Victim counter is read-only, low five bits, decrements per executed instruction.
// [RULE6] Victim counter stays between locked bound and 31.
// [RULE7] Random write targets the entry the victim counter holds.
// [RULE8] Victim counter loads 31 on reset and on any locked-bound write.
// [RULE9] Table exceptions load high-half with faulting page pair and current tag.
// [RULE10] Address-space tag is 8 bits, compared per entry during translation.
// [RULE11] In 64-bit mode region encodes 00 user, 01 supervisor, 11 kernel.
// [RULE12] High-half fill bits ignore writes and read zero.
// [RULE13] Reserved fields read zero; software writes zero there.
// [RULE14] Cache attribute 2 means uncached, all others cached.
// [RULE15] Write-enable flag set allows stores; clear protects the page.
// [RULE16] Hit on invalid entry raises load or store miss trap.
// [RULE17] Global in both low halves makes lookup ignore the tag.
// [RULE18] Page-size mask hides page-number bits during comparison.
// [RULE19] High-half is source or destination for probe, read and both writes.
// [RULE20] Software spaces dependent instructions after changing these registers.
// [RULE21] Locked bound clears on reset; entries below it escape random writes.
// [RULE22] Page-size mask occupies bits 18 to 11.
// [RULE23] Victim counter wraps to 31 instead of passing below the bound.
module tmr_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pipeline side
  input wire logic mode64,
  input wire logic instr_retired,
  input wire tmr_pkg::tmr_op_s op,
  input wire tmr_pkg::tmr_exc_s exc,
  input wire tmr_pkg::tmr_lookup_req_s lookup_req,
  output tmr_pkg::tmr_lookup_rsp_s lookup_rsp
);

  // Table storage, one field array each
  logic [tmr_pkg::PAIR_W-1:0] t_pair [tmr_pkg::NUM_ENTRIES]; // RULE1
  logic [tmr_pkg::MASK_W-1:0] t_mask [tmr_pkg::NUM_ENTRIES];
  logic [7:0] t_tag [tmr_pkg::NUM_ENTRIES];
  logic [1:0] t_region [tmr_pkg::NUM_ENTRIES];
  logic t_global [tmr_pkg::NUM_ENTRIES];
  logic [tmr_pkg::FRAME_W+4:0] t_lo0 [tmr_pkg::NUM_ENTRIES];
  logic [tmr_pkg::FRAME_W+4:0] t_lo1 [tmr_pkg::NUM_ENTRIES];

  // Software-visible registers
  logic probe_fail;
  logic [4:0] slot_index;
  logic [4:0] victim;
  logic [4:0] locked_bound;
  logic [tmr_pkg::PAIR_W-1:0] hi_pair;
  logic [1:0] hi_region;
  logic [7:0] hi_tag;
  logic [31:0] even_low;
  logic [31:0] odd_low;
  logic [tmr_pkg::MASK_W-1:0] page_mask;

  // Bus slave state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wr_merged;

  // Merge written bytes over the current word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Page-number match with size mask and tag / global bypass
  function automatic logic entry_match(input int unsigned e, input logic [tmr_pkg::PAIR_W-1:0] vpn,
                                       input logic [7:0] tag, input logic [1:0] reg_sel,
                                       input logic m64);
    logic [tmr_pkg::PAIR_W-1:0] care;
    care = ~{{(tmr_pkg::PAIR_W - tmr_pkg::MASK_W){1'b0}}, t_mask[e]}; // RULE18
    return (((vpn ^ t_pair[e]) & care) == '0) // RULE18
        && (t_global[e] || (tag == t_tag[e])) // RULE10 RULE17
        && (!m64 || (reg_sel == t_region[e])); // RULE11
  endfunction : entry_match

  // Low word of a table half as software sees it; reserved bits zero
  function automatic logic [31:0] low_word(input logic [tmr_pkg::FRAME_W+4:0] lo, input logic g);
    return {4'h0, lo, g}; // RULE13
  endfunction : low_word

  // Pack a low register into table form, global handled apart
  function automatic logic [tmr_pkg::FRAME_W+4:0] low_pack(input logic [31:0] r);
    return r[tmr_pkg::FRAME_LSB+tmr_pkg::FRAME_W-1:tmr_pkg::VALID_BIT];
  endfunction : low_pack

  // Probe against the high-half register
  logic probe_hit;
  logic [4:0] probe_idx;
  always_comb begin
    probe_hit = 1'b0;
    probe_idx = 5'h00;
    for (int unsigned e = 0; e < tmr_pkg::NUM_ENTRIES; e++) begin
      if (entry_match(e, hi_pair, hi_tag, hi_region, mode64)) begin // RULE19
        probe_hit = 1'b1;
        probe_idx = e[4:0];
      end
    end
  end

  // Translation of a pipeline access
  logic lk_hit;
  logic [4:0] lk_idx;
  always_comb begin
    lk_hit = 1'b0;
    lk_idx = 5'h00;
    for (int unsigned e = 0; e < tmr_pkg::NUM_ENTRIES; e++) begin
      if (entry_match(e, lookup_req.vaddr[31:tmr_pkg::PAIR_LSB], hi_tag, lookup_req.region,
                      mode64)) begin // RULE10
        lk_hit = 1'b1;
        lk_idx = e[4:0];
      end
    end
  end

  // Even/odd half: the page-number bit just below the lowest pair bit left unmasked
  logic [8:0] odd_sel;
  logic lk_odd;
  logic [tmr_pkg::FRAME_W+4:0] lk_lo;
  assign odd_sel = {t_mask[lk_idx], 1'b1} & ~{1'b0, t_mask[lk_idx]};
  assign lk_odd = |(lookup_req.vaddr[18:10] & odd_sel);
  assign lk_lo = lk_odd ? t_lo1[lk_idx] : t_lo0[lk_idx];

  // Lookup answer registered one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lookup_rsp <= '0;
    end else begin
      lookup_rsp.done <= lookup_req.valid;
      lookup_rsp.hit <= lookup_req.valid && lk_hit && lk_lo[0];
      lookup_rsp.frame <= lk_lo[tmr_pkg::FRAME_W+4:5];
      lookup_rsp.uncached <= lk_lo[4:2] == tmr_pkg::CATTR_UNCACHED; // RULE14
      lookup_rsp.load_miss_trap <= lookup_req.valid && lk_hit && !lk_lo[0]
                                   && !lookup_req.store; // RULE16
      lookup_rsp.store_miss_trap <= lookup_req.valid && lk_hit && !lk_lo[0]
                                    && lookup_req.store; // RULE16
      lookup_rsp.modified_trap <= lookup_req.valid && lk_hit && lk_lo[0]
                                  && lookup_req.store && !lk_lo[1]; // RULE15
    end
  end

  // Write channel capture; address and data accepted in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; victim counter is accepted but ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tmr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr)
        tmr_pkg::OFF_SLOT_SELECT, tmr_pkg::OFF_VICTIM, tmr_pkg::OFF_EVEN_LOW,
        tmr_pkg::OFF_ODD_LOW, tmr_pkg::OFF_PAGE_SIZE, tmr_pkg::OFF_LOCKED_BOUND,
        tmr_pkg::OFF_HIGH_HALF: s_axi_bresp <= tmr_pkg::RESP_OKAY;
        default: s_axi_bresp <= tmr_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register read mux
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] hi_word;
  logic [31:0] slot_word;
  assign hi_word = {hi_pair, mode64 ? hi_region : 2'b00, 1'b0, hi_tag}; // RULE12 RULE11
  assign slot_word = {probe_fail, 26'h0, slot_index}; // RULE2 RULE13
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      tmr_pkg::OFF_SLOT_SELECT: rd_word = slot_word;
      tmr_pkg::OFF_VICTIM: rd_word = {27'h0, victim}; // RULE5
      tmr_pkg::OFF_EVEN_LOW: rd_word = even_low;
      tmr_pkg::OFF_ODD_LOW: rd_word = odd_low;
      tmr_pkg::OFF_PAGE_SIZE: rd_word = {13'h0, page_mask, 11'h0}; // RULE22
      tmr_pkg::OFF_LOCKED_BOUND: rd_word = {27'h0, locked_bound};
      tmr_pkg::OFF_HIGH_HALF: rd_word = hi_word;
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read channel: one address at a time, data one cycle later
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tmr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic [31:0] wr_old;
  always_comb begin
    unique case (aw_addr)
      tmr_pkg::OFF_SLOT_SELECT: wr_old = slot_word;
      tmr_pkg::OFF_EVEN_LOW: wr_old = even_low;
      tmr_pkg::OFF_ODD_LOW: wr_old = odd_low;
      tmr_pkg::OFF_PAGE_SIZE: wr_old = {13'h0, page_mask, 11'h0};
      tmr_pkg::OFF_LOCKED_BOUND: wr_old = {27'h0, locked_bound};
      tmr_pkg::OFF_HIGH_HALF: wr_old = hi_word;
      default: wr_old = 32'h0000_0000;
    endcase
  end
  assign wr_merged = merge_bytes(wr_old, w_data, w_strb);

  logic op_read;
  logic op_probe;
  logic op_wr_idx;
  logic op_wr_rand;
  assign op_read = op.valid && (op.code == tmr_pkg::OP_READ);
  assign op_probe = op.valid && (op.code == tmr_pkg::OP_PROBE);
  assign op_wr_idx = op.valid && (op.code == tmr_pkg::OP_WRITE_INDEXED);
  assign op_wr_rand = op.valid && (op.code == tmr_pkg::OP_WRITE_RANDOM);

  // Slot select: probe result wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_fail <= 1'b0;
      slot_index <= 5'h00;
    end else if (op_probe) begin
      probe_fail <= !probe_hit; // RULE3
      if (probe_hit) begin
        slot_index <= probe_idx; // RULE3
      end
    end else if (do_write && aw_addr == tmr_pkg::OFF_SLOT_SELECT) begin
      slot_index <= wr_merged[4:0]; // RULE2
    end
  end

  // Locked bound and victim counter; bound writes restart the counter at the top
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_bound <= tmr_pkg::BOUND_RESET; // RULE21
      victim <= tmr_pkg::TOP_SLOT; // RULE8
    end else if (do_write && aw_addr == tmr_pkg::OFF_LOCKED_BOUND) begin
      locked_bound <= wr_merged[4:0];
      victim <= tmr_pkg::TOP_SLOT; // RULE8
    end else if (instr_retired) begin
      if (victim <= locked_bound) begin
        victim <= tmr_pkg::TOP_SLOT; // RULE23 RULE6
      end else begin
        victim <= victim - 5'h01; // RULE5
      end
    end
  end

  // Entry registers; a table read beats software, exception capture beats both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_pair <= '0;
      hi_region <= 2'b00;
      hi_tag <= 8'h00;
      even_low <= 32'h0000_0000;
      odd_low <= 32'h0000_0000;
      page_mask <= 8'h00;
    end else if (exc.valid) begin
      hi_pair <= exc.vaddr[31:tmr_pkg::PAIR_LSB]; // RULE9
      hi_region <= exc.region; // RULE9 keeps current tag
    end else if (op_read) begin
      hi_pair <= t_pair[slot_index]; // RULE4 RULE19
      hi_region <= t_region[slot_index];
      hi_tag <= t_tag[slot_index];
      page_mask <= t_mask[slot_index];
      even_low <= low_word(t_lo0[slot_index], t_global[slot_index]);
      odd_low <= low_word(t_lo1[slot_index], t_global[slot_index]);
    end else if (do_write) begin
      unique case (aw_addr)
        tmr_pkg::OFF_HIGH_HALF: begin
          hi_pair <= wr_merged[31:tmr_pkg::PAIR_LSB];
          hi_region <= wr_merged[tmr_pkg::REGION_LSB +: 2];
          hi_tag <= wr_merged[7:0]; // RULE12 fill dropped
        end
        tmr_pkg::OFF_EVEN_LOW: even_low <= {4'h0, wr_merged[27:0]}; // RULE13
        tmr_pkg::OFF_ODD_LOW: odd_low <= {4'h0, wr_merged[27:0]};
        tmr_pkg::OFF_PAGE_SIZE: page_mask <= wr_merged[tmr_pkg::MASK_LSB +: tmr_pkg::MASK_W];
        default: ;
      endcase
    end
  end

  // Table write: indexed uses slot select, random uses the victim counter
  logic [4:0] wr_slot;
  assign wr_slot = op_wr_rand ? victim : slot_index; // RULE7 RULE4 RULE21
  always_ff @(posedge aclk) begin
    if (op_wr_idx || op_wr_rand) begin
      t_pair[wr_slot] <= hi_pair & ~{13'h0, page_mask}; // RULE19
      t_region[wr_slot] <= hi_region;
      t_tag[wr_slot] <= hi_tag;
      t_mask[wr_slot] <= page_mask;
      t_global[wr_slot] <= even_low[tmr_pkg::GLOBAL_BIT] & odd_low[tmr_pkg::GLOBAL_BIT]; // RULE17
      t_lo0[wr_slot] <= low_pack(even_low);
      t_lo1[wr_slot] <= low_pack(odd_low);
    end
  end

endmodule : tmr_top

// >>> common/tmr_pkg.sv
package tmr_pkg;

  // Table geometry
  localparam int unsigned NUM_ENTRIES = 32;
  localparam int unsigned IDX_W = 5;
  localparam logic [4:0] TOP_SLOT = 5'h1f;

  // Register byte offsets (register number times four)
  localparam logic [7:0] OFF_SLOT_SELECT = 8'h00;
  localparam logic [7:0] OFF_VICTIM = 8'h04;
  localparam logic [7:0] OFF_EVEN_LOW = 8'h08;
  localparam logic [7:0] OFF_ODD_LOW = 8'h0c;
  localparam logic [7:0] OFF_PAGE_SIZE = 8'h14;
  localparam logic [7:0] OFF_LOCKED_BOUND = 8'h18;
  localparam logic [7:0] OFF_HIGH_HALF = 8'h28;

  // Field positions
  localparam int unsigned PROBE_FAIL_BIT = 31;
  localparam int unsigned PAIR_LSB = 11;
  localparam int unsigned PAIR_W = 21;
  localparam int unsigned REGION_LSB = 9;
  localparam int unsigned MASK_LSB = 11;
  localparam int unsigned MASK_W = 8;
  localparam int unsigned FRAME_LSB = 6;
  localparam int unsigned FRAME_W = 22;
  localparam int unsigned CATTR_LSB = 3;
  localparam int unsigned WEN_BIT = 2;
  localparam int unsigned VALID_BIT = 1;
  localparam int unsigned GLOBAL_BIT = 0;

  // Values after reset and special codes
  localparam logic [4:0] BOUND_RESET = 5'h00;
  localparam logic [2:0] CATTR_UNCACHED = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Address region of a 64-bit virtual address
  typedef enum logic [1:0] {
    REGION_USER = 2'b00,
    REGION_SUPER = 2'b01,
    REGION_KERNEL = 2'b11
  } tmr_region_e;

  // Privileged table operations from the pipeline
  typedef enum logic [1:0] {
    OP_PROBE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE_INDEXED = 2'b10,
    OP_WRITE_RANDOM = 2'b11
  } tmr_op_e;

  typedef struct packed {
    logic valid;
    tmr_op_e code;
  } tmr_op_s;

  // Faulting access reported by the pipeline
  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
    logic [1:0] region;
  } tmr_exc_s;

  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
    logic [1:0] region;
    logic store;
  } tmr_lookup_req_s;

  typedef struct packed {
    logic done;
    logic hit;
    logic [FRAME_W-1:0] frame;
    logic uncached;
    logic load_miss_trap;
    logic store_miss_trap;
    logic modified_trap;
  } tmr_lookup_rsp_s;

endpackage : tmr_pkg

// >>> testbench/tmr_assertions.sv
`timescale 1ns/1ps

module tmr_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Pipeline side
  input wire logic mode64,
  input wire tmr_pkg::tmr_lookup_req_s lookup_req,
  input wire tmr_pkg::tmr_lookup_rsp_s lookup_rsp
);
  logic [7:0] ra;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [4:0] bnd;
  logic [7:0] rq;

  // Track taken addresses and the bound; full strobes assumed by this tracking
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
    if (!aresetn) bnd <= 5'h00;
    else if ($rose(s_axi_bvalid) && wa == tmr_pkg::OFF_LOCKED_BOUND) bnd <= wd[4:0];
  end

  // Address of the word on the read channel, 8'hff while idle
  assign rq = s_axi_rvalid ? ra : 8'hff;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  slot_fields_a: assert property (
    rq == tmr_pkg::OFF_SLOT_SELECT |-> s_axi_rdata[30:5] == 26'h0) else $error("slot bits");
  victim_range_a: assert property (
    rq == tmr_pkg::OFF_VICTIM |-> s_axi_rdata <= 32'h1f && s_axi_rdata[4:0] >= bnd)
    else $error("victim out of range");
  high_fill_a: assert property (
    rq == tmr_pkg::OFF_HIGH_HALF |-> !s_axi_rdata[8]) else $error("fill bit set");
  region_hide_a: assert property (
    rq == tmr_pkg::OFF_HIGH_HALF && !mode64 |-> s_axi_rdata[10:9] == 2'h0)
    else $error("region visible");
  low_resv_a: assert property (
    rq == tmr_pkg::OFF_EVEN_LOW || rq == tmr_pkg::OFF_ODD_LOW |-> s_axi_rdata[31:28] == 4'h0)
    else $error("low reserved set");
  mask_place_a: assert property (
    rq == tmr_pkg::OFF_PAGE_SIZE |-> s_axi_rdata[31:19] == 13'h0 && s_axi_rdata[10:0] == 11'h0)
    else $error("mask outside field");
  bound_field_a: assert property (
    rq == tmr_pkg::OFF_LOCKED_BOUND |-> s_axi_rdata == {27'h0, bnd}) else $error("bound");
  lookup_answer_a: assert property (
    lookup_req.valid |=> lookup_rsp.done) else $error("no lookup answer");
  trap_no_hit_a: assert property (
    lookup_rsp.load_miss_trap || lookup_rsp.store_miss_trap |-> lookup_rsp.done && !lookup_rsp.hit)
    else $error("trap on hit");

  // Main scenarios reached
  cover property (rq == tmr_pkg::OFF_VICTIM && s_axi_rdata[4:0] == bnd);
  cover property (lookup_rsp.hit && lookup_rsp.uncached);
  cover property (lookup_rsp.store_miss_trap);
endmodule : tmr_checker

bind tmr_top tmr_checker checker_i (.*);

// >>> testbench/tmr_pipe_model.sv
`timescale 1ns/1ps

module tmr_pipe_model (
  // Clock
  input wire logic aclk,
  // Pipeline requests
  output logic mode64,
  output logic instr_retired,
  output tmr_pkg::tmr_op_s op,
  output tmr_pkg::tmr_exc_s exc,
  output tmr_pkg::tmr_lookup_req_s lookup_req,
  // Translation answer
  input wire tmr_pkg::tmr_lookup_rsp_s lookup_rsp
);
  // Idle at time zero
  initial begin
    mode64 = 1'b0;
    instr_retired = 1'b0;
    op = '0;
    exc = '0;
    lookup_req = '0;
  end

  // One-cycle pulses, except set_mode, which holds mode64; dropped qualifiers are inverted, not held
  task automatic issue(input tmr_pkg::tmr_op_e c);
    op <= '{1'b1, c};
    @(posedge aclk);
    op <= '{1'b0, tmr_pkg::tmr_op_e'(~c)};
    @(posedge aclk);
  endtask : issue

  task automatic retire();
    instr_retired <= 1'b1;
    @(posedge aclk);
    instr_retired <= 1'b0;
    @(posedge aclk);
  endtask : retire

  task automatic set_mode(input logic m);
    mode64 <= m;
    @(posedge aclk);
  endtask : set_mode

  task automatic fault(input logic [31:0] va, input logic [1:0] rg);
    exc <= '{1'b1, va, rg};
    @(posedge aclk);
    exc <= '{1'b0, ~va, ~rg};
    @(posedge aclk);
  endtask : fault

  // Answer stands one cycle only, so it is caught just after its edge
  task automatic look(input logic [31:0] va, input logic st,
                      output tmr_pkg::tmr_lookup_rsp_s r);
    lookup_req <= '{1'b1, va, 2'h0, st};
    @(posedge aclk);
    lookup_req <= '{1'b0, ~va, 2'h3, ~st};
    #1;
    r = lookup_rsp;
    @(posedge aclk);
  endtask : look
endmodule : tmr_pipe_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic mode64;
  logic instr_retired;
  tmr_pkg::tmr_op_s op;
  tmr_pkg::tmr_exc_s exc;
  tmr_pkg::tmr_lookup_req_s lookup_req;
  tmr_pkg::tmr_lookup_rsp_s lookup_rsp;
  tmr_pkg::tmr_lookup_rsp_s rsp;
  tmr_pkg::tmr_region_e rg;
  int n_fail = 0;
  int checked = 0;

  tmr_top dut (.*);
  tmr_pipe_model pipe (.*);

  // 100 MHz clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic tmo();
    n_fail++;
    give_verdict();
  endtask : tmo

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = tmr_pkg::RESP_OKAY);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 99) tmo();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = tmr_pkg::RESP_OKAY);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 99) tmo();
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rc

  // Flags: done, hit, uncached, load trap, store trap, modified trap
  task automatic lk(input logic [31:0] va, input logic st, input logic [5:0] ef,
                    input logic [21:0] ep);
    pipe.look(va, st, rsp);
    chk({26'h0, rsp.done, rsp.hit, rsp.uncached, rsp.load_miss_trap,
         rsp.store_miss_trap, rsp.modified_trap}, {26'h0, ef});
    if (ef[4] && !ef[0]) chk({10'h0, rsp.frame}, {10'h0, ep});
  endtask : lk

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state, read-only counter, unmapped place
    rc(tmr_pkg::OFF_SLOT_SELECT, 32'h0);
    rc(tmr_pkg::OFF_VICTIM, 32'h1f);
    rc(tmr_pkg::OFF_LOCKED_BOUND, 32'h0);
    wr(tmr_pkg::OFF_VICTIM, 32'h3);
    rc(tmr_pkg::OFF_VICTIM, 32'h1f);
    wr(8'h40, 32'h1, tmr_pkg::RESP_SLVERR);
    rc(8'h40, 32'h0, tmr_pkg::RESP_SLVERR);
    // Table contents start undefined, so clear every entry first
    for (int i = 0; i < tmr_pkg::NUM_ENTRIES; i++) begin
      wr(tmr_pkg::OFF_SLOT_SELECT, 32'(i));
      pipe.issue(tmr_pkg::OP_WRITE_INDEXED);
    end
    // High half fields, region codes and fault capture
    pipe.set_mode(1'b1);
    wr(tmr_pkg::OFF_HIGH_HALF, 32'hffff_ffff);
    rc(tmr_pkg::OFF_HIGH_HALF, 32'hffff_feff);
    rg = rg.first();
    repeat (3) begin
      pipe.fault(32'habcd_e123, rg);
      rc(tmr_pkg::OFF_HIGH_HALF, (32'habcd_e123 & 32'hffff_f800) | {21'h0, rg, 9'h0ff});
      rg = rg.next();
    end
    pipe.set_mode(1'b0);
    rc(tmr_pkg::OFF_HIGH_HALF, 32'habcd_e0ff);
    wr(tmr_pkg::OFF_PAGE_SIZE, 32'hffff_ffff);
    rc(tmr_pkg::OFF_PAGE_SIZE, 32'h0007_f800);
    wr(tmr_pkg::OFF_PAGE_SIZE, 32'h0);
    // Indexed write, then read back into cleared registers
    wr(tmr_pkg::OFF_SLOT_SELECT, 32'h5);
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h1234_583c);
    wr(tmr_pkg::OFF_EVEN_LOW, 32'h0000_1016);
    wr(tmr_pkg::OFF_ODD_LOW, 32'h0000_2004);
    pipe.issue(tmr_pkg::OP_WRITE_INDEXED);
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h0);
    wr(tmr_pkg::OFF_EVEN_LOW, 32'h0);
    wr(tmr_pkg::OFF_ODD_LOW, 32'h0);
    pipe.issue(tmr_pkg::OP_READ);
    rc(tmr_pkg::OFF_HIGH_HALF, 32'h1234_583c);
    rc(tmr_pkg::OFF_EVEN_LOW, 32'h0000_1016);
    rc(tmr_pkg::OFF_ODD_LOW, 32'h0000_2004);
    // Probe hit sets the slot, a miss only raises the flag
    wr(tmr_pkg::OFF_SLOT_SELECT, 32'h0);
    pipe.issue(tmr_pkg::OP_PROBE);
    rc(tmr_pkg::OFF_SLOT_SELECT, 32'h5);
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h1234_583d);
    pipe.issue(tmr_pkg::OP_PROBE);
    rc(tmr_pkg::OFF_SLOT_SELECT, 32'h8000_0005);
    lk(32'h1234_5800, 1'b0, 6'b100000, 22'h0);
    // Translation of entry 5 under its own tag
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h1234_583c);
    lk(32'h1234_5800, 1'b0, 6'b111000, 22'h40);
    lk(32'h1234_5800, 1'b1, 6'b111000, 22'h40);
    lk(32'h1234_5c00, 1'b1, 6'b100010, 22'h0);
    lk(32'h1234_5c00, 1'b0, 6'b100100, 22'h0);
    // Bound write reloads the counter, which wraps at the bound
    wr(tmr_pkg::OFF_LOCKED_BOUND, 32'h1e);
    rc(tmr_pkg::OFF_VICTIM, 32'h1f);
    rc(tmr_pkg::OFF_LOCKED_BOUND, 32'h1e);
    pipe.retire();
    rc(tmr_pkg::OFF_VICTIM, 32'h1e);
    pipe.retire();
    rc(tmr_pkg::OFF_VICTIM, 32'h1f);
    // Random write lands in slot 31: global, read-only, 4K page
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h4000_0011);
    wr(tmr_pkg::OFF_EVEN_LOW, 32'h0000_0043);
    wr(tmr_pkg::OFF_ODD_LOW, 32'h0000_0083);
    wr(tmr_pkg::OFF_PAGE_SIZE, 32'h0000_1800);
    pipe.issue(tmr_pkg::OP_WRITE_RANDOM);
    wr(tmr_pkg::OFF_SLOT_SELECT, 32'h1f);
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h0);
    pipe.issue(tmr_pkg::OP_READ);
    rc(tmr_pkg::OFF_HIGH_HALF, 32'h4000_0011);
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h1234_583c);
    lk(32'h4000_0800, 1'b0, 6'b110000, 22'h1);
    lk(32'h4000_0800, 1'b1, 6'b110001, 22'h1);
    // Region takes part in the match only in 64-bit mode
    pipe.set_mode(1'b1);
    wr(tmr_pkg::OFF_HIGH_HALF, 32'h1234_5a3c);
    pipe.issue(tmr_pkg::OP_PROBE);
    rc(tmr_pkg::OFF_SLOT_SELECT, 32'h8000_001f);
    pipe.set_mode(1'b0);
    pipe.issue(tmr_pkg::OP_PROBE);
    rc(tmr_pkg::OFF_SLOT_SELECT, 32'h0000_0005);
    give_verdict();
  end
endmodule : tb_top
